// >>> core/ltc_teach_ctrl.sv
// Teach and display mode controller for a light curtain receiver.
// Assumes a beam engine that regulates beams on request and reports done,
// blocked beams and the weakest received level; registers over AXI4-Lite.
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module ltc_teach_ctrl
  import ltc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Receiver main connector, configurable line one (pin)
  input  wire logic              configurable_line_one,
  // Beam engine
  output ltc_eng_req_t           eng_req,
  input  wire ltc_eng_rsp_t      eng_rsp,
  input  wire logic [LVL_W-1:0]  first_beam_in,
  input  wire logic [LVL_W-1:0]  last_beam_in,
  input  wire logic [BEAM_W-1:0] interrupted_in,
  input  wire logic [IO_W-1:0]   io_state_in,
  // Display and storage
  output logic                   align_mode,
  output logic                   teach_busy,
  output logic [LVL_W-1:0]       first_beam_level,
  output logic [LVL_W-1:0]       last_beam_level,
  output logic [BEAM_W-1:0]      interrupted_beam_total,
  output logic [IO_W-1:0]        io_display,
  output logic                   store_nv,
  output logic                   store_ram
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  ltc_cfg_t          cfg;
  logic [LVL_W-1:0]  min_level;
  ltc_state_t        state;
  logic              teach_ok;
  logic              teach_err;
  logic              teach_valid;
  logic              from_align;
  logic              powerup_pending;
  logic              start_pulse;

  logic [7:0]        aw_addr;
  logic              aw_held;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              w_held;
  logic              wr_fire;
  logic              rd_fire;
  logic [31:0]       next_rdata;
  logic              rd_hit;

  logic              cmd_panel;
  logic              cmd_bus;
  logic              cmd_sw;
  logic              cmd_proc;
  logic              cmd_align;

  // ----------------------------------------------------------------------
  // Teach line input
  // ----------------------------------------------------------------------
  logic [2:0]        line_sync;
  logic              line_level;
  logic              line_active;
  logic [CNT_W-1:0]  pulse_cnt;
  logic              line_teach;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_sync <= 3'h0;
    end else begin
      line_sync <= {line_sync[1:0], configurable_line_one};
    end
  end

  // Level changes only when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_level <= 1'b0;
    end else if (line_sync[1] == line_sync[2]) begin
      line_level <= line_sync[2];
    end
  end

  assign line_active = line_level ^ cfg.npn;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_cnt  <= '0;
      line_teach <= 1'b0;
    end else begin
      line_teach <= 1'b0;
      if (line_active) begin
        if (pulse_cnt != CNT_W'(PULSE_MAX_CYC + 1)) begin
          pulse_cnt <= pulse_cnt + CNT_W'(1);
        end
      end else begin
        pulse_cnt <= '0;
        if (cfg.line_is_teach &&
            pulse_cnt >= CNT_W'(PULSE_MIN_CYC) &&
            pulse_cnt <= CNT_W'(PULSE_MAX_CYC)) begin
          line_teach <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite write
  // ----------------------------------------------------------------------
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr == ADDR_CTRL || aw_addr == ADDR_CMD ||
                       aw_addr == ADDR_LEVEL) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign cmd_panel = wr_fire && aw_addr == ADDR_CMD && w_strb[0] &&
                     w_data[CMD_PANEL_TEACH];
  assign cmd_bus   = wr_fire && aw_addr == ADDR_CMD && w_strb[0] &&
                     w_data[CMD_BUS_TEACH];
  assign cmd_sw    = wr_fire && aw_addr == ADDR_CMD && w_strb[0] &&
                     w_data[CMD_SW_TEACH];
  assign cmd_proc  = wr_fire && aw_addr == ADDR_CMD && w_strb[0] &&
                     w_data[CMD_TO_PROCESS];
  assign cmd_align = wr_fire && aw_addr == ADDR_CMD && w_strb[0] &&
                     w_data[CMD_TO_ALIGN];

  // Configuration register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= '{npn: CTRL_RESET[CTRL_NPN],
               volatile_store: CTRL_RESET[CTRL_VOLATILE],
               power_up_teach: CTRL_RESET[CTRL_PWRUP],
               line_is_teach: CTRL_RESET[CTRL_LINE_TEACH],
               sensitivity: '0, blank_areas: '0, margin: '0};
      min_level <= LVL_MIN_DEFAULT;
    end else if (wr_fire && aw_addr == ADDR_CTRL) begin
      if (w_strb[0]) begin
        cfg.npn            <= w_data[CTRL_NPN];
        cfg.volatile_store <= w_data[CTRL_VOLATILE];
        cfg.power_up_teach <= w_data[CTRL_PWRUP];
        cfg.line_is_teach  <= w_data[CTRL_LINE_TEACH];
        cfg.sensitivity    <= w_data[CTRL_SENS_LSB +: SENS_W];
      end
      if (w_strb[1]) begin
        if (w_data[CTRL_BLK_LSB +: BLK_W] <= BLK_MAX) begin
          cfg.blank_areas <= w_data[CTRL_BLK_LSB +: BLK_W];
        end
        cfg.margin <= w_data[CTRL_MARGIN_LSB +: MRG_W];
      end
    end else if (wr_fire && aw_addr == ADDR_LEVEL && w_strb[0]) begin
      min_level <= w_data[LVL_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Display mode and power-up teach
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      align_mode <= 1'b0;
    end else if (state == LTC_IDLE) begin
      if (cmd_align) begin
        align_mode <= 1'b1;
      end else if (cmd_proc) begin
        align_mode <= 1'b0;
      end
    end else if (state == LTC_DONE) begin
      align_mode <= from_align;
    end
  end

  // Power-up option is sampled after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      powerup_pending <= 1'b1;
    end else if (state == LTC_IDLE) begin
      powerup_pending <= 1'b0;
    end
  end

  assign start_pulse = cmd_panel || cmd_bus || cmd_sw || line_teach ||
                       (powerup_pending && cfg.power_up_teach);

  // ----------------------------------------------------------------------
  // Teach sequence
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= LTC_IDLE;
      from_align <= 1'b0;
      teach_ok   <= 1'b0;
      teach_err  <= 1'b0;
      teach_valid <= 1'b0;
      eng_req    <= '0;
    end else begin
      eng_req.start <= 1'b0;
      unique case (state)
        LTC_IDLE: begin
          if (start_pulse) begin
            from_align <= align_mode;
            state      <= LTC_START;
          end
        end
        LTC_START: begin
          eng_req.start       <= 1'b1;
          eng_req.sensitivity <= cfg.sensitivity;
          eng_req.blanking    <= cfg.blank_areas != '0;
          eng_req.margin      <= cfg.margin;
          state               <= LTC_WAIT;
        end
        LTC_WAIT: begin
          if (eng_rsp.done) begin
            if (eng_rsp.min_level < min_level) begin
              teach_ok <= 1'b0;
            end else if (!eng_req.blanking && eng_rsp.any_blocked) begin
              teach_ok <= 1'b0;
            end else begin
              teach_ok <= 1'b1;
            end
            teach_err <= (eng_rsp.min_level < min_level) ||
                         (!eng_req.blanking && eng_rsp.any_blocked);
            teach_valid <= 1'b1;
            state <= LTC_DONE;
          end
        end
        LTC_DONE: begin
          state <= LTC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      teach_busy <= 1'b0;
      store_nv   <= 1'b0;
      store_ram  <= 1'b0;
    end else begin
      teach_busy <= state != LTC_IDLE || start_pulse;
      store_nv   <= state == LTC_DONE && teach_ok && !cfg.volatile_store;
      store_ram  <= state == LTC_DONE && teach_ok && cfg.volatile_store;
    end
  end

  // ----------------------------------------------------------------------
  // Display outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_beam_level       <= LVL_NONE;
      last_beam_level        <= LVL_NONE;
      interrupted_beam_total <= '0;
      io_display             <= '0;
    end else begin
      interrupted_beam_total <= interrupted_in;
      io_display             <= io_state_in;
      if (teach_valid && teach_err) begin
        first_beam_level <= LVL_NONE;
        last_beam_level  <= LVL_NONE;
      end else if (teach_valid && teach_ok && state == LTC_DONE) begin
        first_beam_level <= LVL_FULL;
        last_beam_level  <= LVL_FULL;
      end else begin
        first_beam_level <= first_beam_in;
        last_beam_level  <= last_beam_in;
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read
  // ----------------------------------------------------------------------
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_hit     = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CTRL: begin
        next_rdata[CTRL_NPN]        = cfg.npn;
        next_rdata[CTRL_VOLATILE]   = cfg.volatile_store;
        next_rdata[CTRL_PWRUP]      = cfg.power_up_teach;
        next_rdata[CTRL_LINE_TEACH] = cfg.line_is_teach;
        next_rdata[CTRL_SENS_LSB +: SENS_W]  = cfg.sensitivity;
        next_rdata[CTRL_BLK_LSB +: BLK_W]    = cfg.blank_areas;
        next_rdata[CTRL_MARGIN_LSB +: MRG_W] = cfg.margin;
      end
      ADDR_CMD:    next_rdata = 32'h0000_0000;
      ADDR_STATUS: next_rdata[3:0] = {teach_err, teach_ok, teach_busy,
                                      align_mode};
      ADDR_BLANK:  next_rdata[BLK_W-1:0] = cfg.blank_areas;
      ADDR_LEVEL:  next_rdata[LVL_W-1:0] = min_level;
      ADDR_PROC:   next_rdata[BEAM_W+IO_W-1:0] = {io_display,
                                                  interrupted_beam_total};
      ADDR_ENG:    next_rdata[2*LVL_W-1:0] = {last_beam_level,
                                              first_beam_level};
      ADDR_RESULT: next_rdata[1:0] = {teach_valid, teach_ok};
      default:     rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !rd_fire;
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= next_rdata;
        s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// >>> core/ltc_pkg.sv
// Package for the light curtain teach controller: register map, fields,
// timing constants and carrier types.
// Assumes a 20 MHz aclk and a 32-bit AXI4-Lite register bus.
package ltc_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ        = 20_000_000;
  localparam int PULSE_MIN_MS  = 20;
  localparam int PULSE_MAX_MS  = 80;
  localparam int PULSE_MIN_CYC = (PULSE_MIN_MS * (CLK_HZ / 1000)) + 1;
  localparam int PULSE_MAX_CYC = PULSE_MAX_MS * (CLK_HZ / 1000) - 1;
  localparam int CNT_W         = 22;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CMD    = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_BLANK  = 8'h0C;
  localparam logic [7:0] ADDR_LEVEL  = 8'h10;
  localparam logic [7:0] ADDR_PROC   = 8'h14;
  localparam logic [7:0] ADDR_ENG    = 8'h18;
  localparam logic [7:0] ADDR_RESULT = 8'h1C;

  // ----------------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------------
  // CTRL
  localparam int CTRL_NPN       = 0;
  localparam int CTRL_VOLATILE  = 1;
  localparam int CTRL_PWRUP     = 2;
  localparam int CTRL_LINE_TEACH = 3;
  localparam int CTRL_SENS_LSB  = 4;
  localparam int CTRL_BLK_LSB   = 8;
  localparam int CTRL_MARGIN_LSB = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0008;
  // CMD (write one to act)
  localparam int CMD_PANEL_TEACH = 0;
  localparam int CMD_BUS_TEACH   = 1;
  localparam int CMD_SW_TEACH    = 2;
  localparam int CMD_TO_PROCESS  = 3;
  localparam int CMD_TO_ALIGN    = 4;
  // Widths
  localparam int LVL_W  = 8;
  localparam int BEAM_W = 11;
  localparam int SENS_W = 2;
  localparam int BLK_W  = 3;
  localparam int MRG_W  = 4;
  localparam int IO_W   = 4;
  localparam logic [BLK_W-1:0] BLK_MAX = 3'h4;
  localparam logic [LVL_W-1:0] LVL_FULL = 8'hFF;
  localparam logic [LVL_W-1:0] LVL_NONE = 8'h00;
  localparam logic [LVL_W-1:0] LVL_MIN_DEFAULT = 8'h80;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    LTC_IDLE  = 4'b0001,
    LTC_START = 4'b0010,
    LTC_WAIT  = 4'b0100,
    LTC_DONE  = 4'b1000
  } ltc_state_t;

  typedef struct packed {
    logic             npn;
    logic             volatile_store;
    logic             power_up_teach;
    logic             line_is_teach;
    logic [SENS_W-1:0] sensitivity;
    logic [BLK_W-1:0]  blank_areas;
    logic [MRG_W-1:0]  margin;
  } ltc_cfg_t;

  // Request to and answer from the beam measurement engine
  typedef struct packed {
    logic             start;
    logic             blanking;
    logic [SENS_W-1:0] sensitivity;
    logic [MRG_W-1:0]  margin;
  } ltc_eng_req_t;

  typedef struct packed {
    logic             done;
    logic             any_blocked;
    logic [LVL_W-1:0] min_level;
  } ltc_eng_rsp_t;

endpackage

// >>> tb/ltc_plc_model.sv
// Controller model that pulses the teach line for a set width.
// Assumes go lasts one cycle; width is given in aclk cycles.
`timescale 1ns/1ps
module ltc_plc_model (
  input  wire logic        aclk,
  input  wire logic        npn,
  input  wire logic        go,
  input  wire logic [20:0] width,
  output logic             line
);
  logic [20:0] cnt = 21'h0;
  always @(posedge aclk) begin
    if (go)
      cnt <= width;
    else if (cnt != 21'h0)
      cnt <= cnt - 21'h1;
  end
  // Idle inactive; active high for PNP, low for NPN
  assign line = (cnt != 21'h0) ^ npn;
endmodule

// >>> tb/ltc_teach_ctrl_sva.sv
// Port checker for the teach controller.
// Bound to every ltc_teach_ctrl instance.
`timescale 1ns/1ps
module ltc_teach_ctrl_sva
  import ltc_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [31:0]       s_axi_rdata,
  input wire ltc_eng_req_t      eng_req,
  input wire ltc_eng_rsp_t      eng_rsp,
  input wire logic              teach_busy,
  input wire logic              store_nv,
  input wire logic              store_ram,
  input wire logic [LVL_W-1:0]  first_beam_level,
  input wire logic [LVL_W-1:0]  last_beam_level,
  input wire logic [BEAM_W-1:0] interrupted_beam_total,
  input wire logic [BEAM_W-1:0] interrupted_in,
  input wire logic [IO_W-1:0]   io_display,
  input wire logic [IO_W-1:0]   io_state_in
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------
  // Bus answers, teach steps and display copy
  // ------------------------------------------------------------
  sequence s_launch;
    ##[0:2] eng_req.start;
  endsequence
  sequence s_full;
    first_beam_level == LVL_FULL && last_beam_level == LVL_FULL;
  endsequence
  sequence s_done_seen;
    $past(eng_rsp.done) || $past(eng_rsp.done, 2);
  endsequence
  a_bvalid_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped before bready");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed before rready");
  a_start_pulse: assert property (
    eng_req.start |-> teach_busy ##1 !eng_req.start)
    else $error("engine start not a single pulse in a teach");
  a_busy_launch: assert property ($rose(teach_busy) |-> s_launch)
    else $error("teach began without engine start");
  a_store_full: assert property ((store_nv || store_ram) |-> s_full)
    else $error("stored teach without full levels");
  a_store_done: assert property (
    (store_nv || store_ram) |-> s_done_seen)
    else $error("store pulse without engine done");
  a_store_kind: assert property (!(store_nv && store_ram))
    else $error("both storage kinds pulsed");
  a_display_copy: assert property ($past(aresetn) |->
    interrupted_beam_total == $past(interrupted_in)
    && io_display == $past(io_state_in))
    else $error("process display not a copy of inputs");
endmodule
bind ltc_teach_ctrl ltc_teach_ctrl_sva ltc_teach_ctrl_sva_inst (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .eng_req, .eng_rsp, .teach_busy,
  .store_nv, .store_ram, .first_beam_level, .last_beam_level,
  .interrupted_beam_total, .interrupted_in, .io_display, .io_state_in);

// >>> tb/light_curtain_teach_control_test.sv
// Self-checking bench for the teach controller.
// Bench plays AXI master and beam engine; model drives the teach line.
`timescale 1ns/1ps
module light_curtain_teach_control_test
  import ltc_pkg::*;
;
  logic              aclk = 1'h0;
  logic              aresetn = 1'h0;
  logic [7:0]        s_axi_awaddr = 8'h00;
  logic [7:0]        s_axi_araddr = 8'h00;
  logic [31:0]       s_axi_wdata = 32'h0;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic              s_axi_awvalid = 1'h0;
  logic              s_axi_wvalid = 1'h0;
  logic              s_axi_bready = 1'h0;
  logic              s_axi_arvalid = 1'h0;
  logic              s_axi_rready = 1'h0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [31:0]       s_axi_rdata;
  logic              configurable_line_one;
  logic              plc_npn = 1'h0;
  logic              plc_go = 1'h0;
  ltc_eng_req_t      eng_req;
  ltc_eng_rsp_t      eng_rsp = '0;
  logic [LVL_W-1:0]  first_beam_in = 8'h00, last_beam_in = 8'h00;
  logic [BEAM_W-1:0] interrupted_in = 11'h000;
  logic [IO_W-1:0]   io_state_in = 4'h0;
  logic              align_mode, teach_busy, store_nv, store_ram;
  logic [LVL_W-1:0]  first_beam_level, last_beam_level;
  logic [BEAM_W-1:0] interrupted_beam_total;
  logic [IO_W-1:0]   io_display;
  logic [1:0]        e_sens = 2'h0;
  logic [3:0]        e_mrg = 4'h0;
  logic              e_blk = 1'h0, seen_nv, seen_ram;
  logic [31:0]       rnd = 32'h6223;
  logic [1:0]        bq[$];
  logic [33:0]       rq[$];
  int                failures = 0, num_checks = 0;
  int                nstart = 0, dly = 0, cyc = 0;

  always #25 aclk = ~aclk;

  ltc_teach_ctrl ltc_teach_ctrl_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .configurable_line_one, .eng_req,
    .eng_rsp, .first_beam_in, .last_beam_in, .interrupted_in,
    .io_state_in, .align_mode, .teach_busy, .first_beam_level,
    .last_beam_level, .interrupted_beam_total, .io_display,
    .store_nv, .store_ram);
  ltc_plc_model ltc_plc_model_inst (.aclk(aclk), .npn(plc_npn),
    .go(plc_go), .width(21'h3E8), .line(configurable_line_one));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string n, input logic [31:0] s,
                       input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY,
                    input logic [3:0] s = 4'hF);
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) aw = 1'h1;
      if (s_axi_wready) w = 1'h1;
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
    end while (!(aw && w));
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    rq.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic teach(input int b, input logic [31:0] st,
                       input logic nv, input logic ram);
    int s0;
    s0 = nstart;
    seen_nv = 1'h0;
    seen_ram = 1'h0;
    wr(ADDR_CMD, 32'h1 << b);
    while (nstart == s0) @(posedge aclk);
    do @(posedge aclk); while (teach_busy !== 1'h0);
    rd(ADDR_STATUS, st);
    check("store_nv", seen_nv, nv);
    check("store_ram", seen_ram, ram);
  endtask

  // ------------------------------------------------------------
  // Answer monitor, beam engine and timeout
  // ------------------------------------------------------------
  always @(posedge aclk) begin
    logic [33:0] e;
    if (s_axi_bvalid && s_axi_bready)
      check("bresp", s_axi_bresp, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      check("rresp", s_axi_rresp, e[33:32]);
      check("rdata", s_axi_rdata, e[31:0]);
    end
    eng_rsp.done <= 1'h0;
    if (store_nv) seen_nv = 1'h1;
    if (store_ram) seen_ram = 1'h1;
    if (eng_req.start) begin
      nstart++;
      dly = 3 + rnd[2:0];
      check("sensitivity", eng_req.sensitivity, e_sens);
      check("blanking", eng_req.blanking, e_blk);
      check("margin", eng_req.margin, e_mrg);
    end else if (dly > 0) begin
      dly--;
      if (dly == 0) eng_rsp.done <= 1'h1;
    end
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int s0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rnd = lfsr(lfsr(rnd));
    first_beam_in <= rnd[7:0];
    last_beam_in <= rnd[15:8];
    interrupted_in <= rnd[26:16];
    io_state_in <= rnd[30:27];
    repeat (2) @(posedge aclk);
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_LEVEL, 32'(LVL_MIN_DEFAULT));
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(ADDR_STATUS, 32'h1, RESP_SLVERR);
    rd(ADDR_PROC, 32'({io_state_in, interrupted_in}));
    rd(ADDR_ENG, 32'({last_beam_in, first_beam_in}));
    wr(ADDR_CMD, 32'h10);
    rd(ADDR_STATUS, 32'h1);
    wr(ADDR_CMD, 32'h8);
    rd(ADDR_STATUS, 32'h0);
    eng_rsp.min_level <= LVL_FULL;
    for (int b = 0; b < 3; b++) begin
      if (b > 0) wr(ADDR_CMD, b == 1 ? 32'h10 : 32'h8);
      teach(b, b == 1 ? 32'h5 : 32'h4, 1'h1, 1'h0);
    end
    rd(ADDR_RESULT, 32'h3);
    eng_rsp.min_level <= 8'h10;
    teach(0, 32'h8, 1'h0, 1'h0);
    rd(ADDR_ENG, 32'h0);
    rd(ADDR_RESULT, 32'h2);
    eng_rsp.min_level <= LVL_FULL;
    eng_rsp.any_blocked <= 1'h1;
    teach(1, 32'h8, 1'h0, 1'h0);
    e_blk = 1'h1;
    e_mrg = 4'h5;
    e_sens = 2'h3;
    wr(ADDR_CTRL, 32'h523A);
    teach(2, 32'h4, 1'h0, 1'h1);
    wr(ADDR_CTRL, 32'h553A);
    rd(ADDR_BLANK, 32'h2);
    // Byte lane zero only: areas and margin keep their values
    wr(ADDR_CTRL, 32'h0108, RESP_OKAY, 4'h1);
    rd(ADDR_CTRL, 32'h5208);
    for (int n = 0; n < 2; n++) begin
      wr(ADDR_CTRL, 32'h8 | n);
      plc_npn <= n[0];
      repeat (20) @(posedge aclk);
      s0 = nstart;
      plc_go <= 1'h1;
      @(posedge aclk);
      plc_go <= 1'h0;
      repeat (1100) @(posedge aclk);
      check("line_teach_count", nstart, s0);
    end
    complete_run();
  end
endmodule
